//--- shared/tsr_params.svh
// constants of the temperature sensor register set
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH
`define TSR_SEL_TEMP    2'h0
`define TSR_SEL_CFG     2'h1
`define TSR_SEL_LOW     2'h2
`define TSR_SEL_UP      2'h3
`define TSR_TEMP_RST    16'h0000
`define TSR_CFG_RST     8'h00
`define TSR_LOW_RST     16'h4B00
`define TSR_UP_RST      16'h5000
`define TSR_LIM_MASK    16'hFF80
`define TSR_CFG_ONESHOT 7
`define TSR_CFG_RES_LSB 5
`define TSR_CFG_FQ_LSB  3
`define TSR_CFG_POL     2
`define TSR_CFG_INT     1
`define TSR_CFG_SHDN    0
`define TSR_CLK_HZ      40000000
`define TSR_CONV9_MS    30
`define TSR_CONV9_CYC   (`TSR_CONV9_MS * (`TSR_CLK_HZ / 1000))
`endif

//--- shared/tsr_pkg.sv
// types of the temperature sensor register set
package tsr_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tsr_wbyte_t;
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_PTR  = 4'b0010,
    PH_WR   = 4'b0100,
    PH_RD   = 4'b1000
  } tsr_phase_t;
endpackage

//--- design/tsr_register_set.sv
// register set, conversion timing and alert logic of the temperature sensor
//
// Function
// RULE1 - two low selector bits pick register
// RULE2 - upper six selector bits unimplemented, read zero
// RULE3 - temperature result is read-only 16 bits
// RULE4 - result is temperature times sixteen, low nibble zero
// RULE5 - refresh once per conversion, 30 to 240 ms
// RULE6 - reads never torn by an update
// RULE7 - fraction bits below resolution stay zero
// RULE8 - 8-bit configuration powers up zero
// RULE9 - bits 6:5 select 9 to 12 bits
// RULE10 - bits 4:3 select fault count 1,2,4,6
// RULE11 - bit 2 sets alert polarity
// RULE12 - bit 1 selects interrupt or comparator
// RULE13 - bit 0 stops conversions
// RULE14 - bit 7 requests single shot conversion
// RULE15 - single shot done clears bit 7
// RULE16 - comparator alert above upper, until below lower
// RULE17 - host sends selector with upper bits zero
// RULE18 - last selector kept across transactions
// RULE19 - alert needs consecutive out-of-limit conversions
// RULE20 - 16-bit transfers upper byte first
// RULE21 - reset restores defaults and selects temperature
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"
module tsr_register_set
  import tsr_pkg::*;
#(
  parameter int unsigned CONV9_CYCLES = `TSR_CONV9_CYC
) (
  input  wire logic        clk,        // 40 MHz clock
  input  wire logic        reset_n,    // synchronous reset, active low
  input  wire logic        clkEn,      // freezes all state while low
  input  wire logic        xferStart,  // start of an addressed transaction
  input  wire logic        xferRead,   // direction with xferStart, 1 = read
  input  wire tsr_wbyte_t  wrByte,     // byte received from the host
  input  wire logic        rdStrobe,   // host asks for the next byte
  input  wire logic [11:0] sensorCode, // converter output, degrees times 16
  output logic [7:0]       rdData,     // byte for the host
  output logic             rdValid,    // rdData updated
  output logic             convDone,   // conversion completed
  output logic             alertOut    // alert pin level
);
  tsr_phase_t  phase_q;
  logic [1:0]  sel_q;
  logic [7:0]  cfg_q;
  logic [15:0] temp_q;
  logic [15:0] low_q;
  logic [15:0] up_q;
  logic [7:0]  wrHi_q;
  logic        wrHalf_q;
  logic        rdHalf_q;
  logic [7:0]  rdSnap_q;
  logic [7:0]  rdData_q;
  logic        rdValid_q;
  logic [23:0] convCnt_q;
  logic [2:0]  faultCnt_q;
  logic        compState_q;
  logic        intPend_q;
  logic        wrTake;
  logic        rdTake;
  logic        cfgWr;
  logic        runConv;
  logic [23:0] convLen;
  logic [15:0] tempNew;
  logic [15:0] regSel;
  logic        outOfLimit;
  logic [2:0]  faultNeed;
  logic        alertActive;

  function automatic logic [15:0] resMask(input logic [1:0] res);
    case (res)
      2'h0:    resMask = 16'hFF80;
      2'h1:    resMask = 16'hFFC0;
      2'h2:    resMask = 16'hFFE0;
      default: resMask = 16'hFFF0;
    endcase
  endfunction

  assign wrTake  = clkEn & wrByte.valid;
  assign rdTake  = clkEn & rdStrobe & (phase_q == PH_RD);
  assign cfgWr   = wrTake & (phase_q == PH_WR) & (sel_q == `TSR_SEL_CFG);
  assign runConv = ~cfg_q[`TSR_CFG_SHDN] | cfg_q[`TSR_CFG_ONESHOT]; // [RULE13] [RULE14]
  // each extra resolution bit doubles the conversion time
  assign convLen = 24'(CONV9_CYCLES) << cfg_q[6:5]; // [RULE5] [RULE9]
  assign convDone = clkEn & runConv & (convCnt_q >= convLen - 24'h000001);
  assign tempNew = {sensorCode, 4'h0} & resMask(cfg_q[6:5]); // [RULE4] [RULE7]

  always_comb begin
    case (sel_q) // [RULE1]
      `TSR_SEL_TEMP: regSel = temp_q;
      `TSR_SEL_CFG:  regSel = {8'h00, cfg_q};
      `TSR_SEL_LOW:  regSel = low_q;
      default:       regSel = up_q;
    endcase
  end

  always_comb begin
    case (cfg_q[4:3]) // [RULE10]
      2'h0:    faultNeed = 3'h1;
      2'h1:    faultNeed = 3'h2;
      2'h2:    faultNeed = 3'h4;
      default: faultNeed = 3'h6;
    endcase
  end

  // out of limit means crossing the limit that would change the state
  assign outOfLimit = compState_q ? ($signed(tempNew) < $signed(low_q)) :
                                    ($signed(tempNew) > $signed(up_q)); // [RULE16]

  // transaction phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_q <= PH_IDLE;
    end else if (clkEn) begin
      if (xferStart) begin
        phase_q <= xferRead ? PH_RD : PH_PTR;
      end else if (wrByte.valid && phase_q == PH_PTR) begin
        phase_q <= PH_WR;
      end
    end
  end

  // selector keeps its value until a new one is written
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_q <= `TSR_SEL_TEMP; // [RULE21]
    end else if (wrTake && phase_q == PH_PTR) begin
      sel_q <= wrByte.data[1:0]; // [RULE2] [RULE17] [RULE18]
    end
  end

  // limit writes commit on the lower byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_q    <= `TSR_LOW_RST; // [RULE21]
      up_q     <= `TSR_UP_RST;
      wrHi_q   <= 8'h00;
      wrHalf_q <= 1'b0;
    end else if (clkEn) begin
      if (xferStart) begin
        wrHalf_q <= 1'b0;
      end else if (wrByte.valid && phase_q == PH_WR && sel_q != `TSR_SEL_CFG) begin
        wrHalf_q <= ~wrHalf_q; // [RULE20]
        if (!wrHalf_q) begin
          wrHi_q <= wrByte.data;
        end else if (sel_q == `TSR_SEL_LOW) begin
          low_q <= {wrHi_q, wrByte.data} & `TSR_LIM_MASK;
        end else if (sel_q == `TSR_SEL_UP) begin
          up_q <= {wrHi_q, wrByte.data} & `TSR_LIM_MASK;
        end
      end
    end
  end

  // configuration; a host write wins over the self clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q <= `TSR_CFG_RST; // [RULE8]
    end else if (cfgWr) begin
      cfg_q <= wrByte.data;
    end else if (convDone && cfg_q[`TSR_CFG_SHDN]) begin
      cfg_q[`TSR_CFG_ONESHOT] <= 1'b0; // [RULE15]
    end
  end

  // conversion timer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      convCnt_q <= 24'h000000;
    end else if (clkEn) begin
      if (!runConv || convDone) begin
        convCnt_q <= 24'h000000;
      end else begin
        convCnt_q <= convCnt_q + 24'h000001;
      end
    end
  end

  // result changes only as a whole word at conversion end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temp_q <= `TSR_TEMP_RST;
    end else if (convDone) begin
      temp_q <= tempNew; // [RULE3] [RULE5] [RULE6]
    end
  end

  // fault queue and comparator state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      faultCnt_q  <= 3'h0;
      compState_q <= 1'b0;
    end else if (convDone) begin
      if (!outOfLimit) begin
        faultCnt_q <= 3'h0; // [RULE19]
      end else if (faultCnt_q + 3'h1 >= faultNeed) begin
        faultCnt_q  <= 3'h0;
        compState_q <= ~compState_q; // [RULE16] [RULE19]
      end else begin
        faultCnt_q <= faultCnt_q + 3'h1;
      end
    end
  end

  // interrupt mode: each state change latches, any read clears, set wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      intPend_q <= 1'b0;
    end else if (clkEn) begin
      if (convDone && outOfLimit && faultCnt_q + 3'h1 >= faultNeed) begin
        intPend_q <= 1'b1; // [RULE12]
      end else if (rdTake) begin
        intPend_q <= 1'b0;
      end
    end
  end

  assign alertActive = cfg_q[`TSR_CFG_INT] ? intPend_q : compState_q; // [RULE12]
  assign alertOut    = cfg_q[`TSR_CFG_POL] ? alertActive : ~alertActive; // [RULE11]

  // read path: the lower byte comes from a copy taken with the upper byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdData_q  <= 8'h00;
      rdSnap_q  <= 8'h00;
      rdHalf_q  <= 1'b0;
      rdValid_q <= 1'b0;
    end else if (clkEn) begin
      rdValid_q <= rdTake;
      if (xferStart) begin
        rdHalf_q <= 1'b0;
      end else if (rdTake) begin
        if (sel_q == `TSR_SEL_CFG) begin
          rdData_q <= cfg_q;
        end else if (!rdHalf_q) begin
          rdData_q <= regSel[15:8]; // [RULE20]
          rdSnap_q <= regSel[7:0]; // [RULE6]
          rdHalf_q <= 1'b1;
        end else begin
          rdData_q <= rdSnap_q;
          rdHalf_q <= 1'b0;
        end
      end
    end
  end

  assign rdData  = rdData_q;
  assign rdValid = rdValid_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_temp_ro: assert property (wrTake && phase_q == PH_WR && // [RULE3]
    sel_q == `TSR_SEL_TEMP && !convDone |=> $stable(temp_q))
    else $error("temperature changed by a write");
  chk_temp_nibble: assert property (temp_q[3:0] == 4'h0) // [RULE4]
    else $error("temperature low nibble not zero");
  chk_res_mask: assert property (convDone |=> // [RULE7]
    (temp_q & ~resMask($past(cfg_q[6:5]))) == 16'h0000)
    else $error("fraction bits below resolution set");
  chk_cfg_reset: assert property ($rose(reset_n) |-> cfg_q == 8'h00 && sel_q == 2'h0) // [RULE8]
    else $error("reset defaults wrong");
  chk_oneshot_clear: assert property (convDone && cfg_q[0] && cfg_q[7] && // [RULE15]
    !cfgWr |=> !cfg_q[7]) else $error("single shot bit not cleared");
  chk_shdn_idle: assert property (cfg_q[0] && !cfg_q[7] |-> !convDone) // [RULE13]
    else $error("conversion during shutdown");
  chk_sel_hold: assert property (!(wrTake && phase_q == PH_PTR) |=> $stable(sel_q)) // [RULE18]
    else $error("selector changed without a write");
  chk_rd_upper: assert property (rdTake && sel_q != `TSR_SEL_CFG && !rdHalf_q // [RULE20]
    |=> rdValid && rdData == $past(regSel[15:8])) else $error("upper byte wrong");
  chk_rd_lower: assert property (rdTake && sel_q != `TSR_SEL_CFG && rdHalf_q // [RULE6]
    |=> rdValid && rdData == $past(rdSnap_q)) else $error("lower byte torn");
  chk_fault_restart: assert property (convDone && !outOfLimit |=> faultCnt_q == 3'h0) // [RULE19]
    else $error("fault count not restarted");
  chk_alert_level: assert property (convDone && !cfg_q[1] && cfg_q[4:3] == 2'h0 && // [RULE16]
    !compState_q && outOfLimit && !cfgWr |=> alertOut == cfg_q[2])
    else $error("alert not raised");

  cov_conv: cover property (convDone);
  cov_oneshot: cover property (convDone && cfg_q[0] && cfg_q[7]);
  cov_alert: cover property (convDone && outOfLimit && faultCnt_q + 3'h1 >= faultNeed);
  cov_pair: cover property (rdTake && !rdHalf_q && sel_q == `TSR_SEL_TEMP ##[1:8] rdTake);
endmodule
`default_nettype wire

//--- dv/tsr_host_model.sv
// host-side byte model driving the register set
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model
  import tsr_pkg::*;
(
  input  wire logic       clk,       // bench clock
  input  wire logic [7:0] rdData,    // byte from device
  input  wire logic       rdValid,   // byte ready
  output tsr_wbyte_t      wrByte,    // byte to device
  output logic            xferStart, // transaction start
  output logic            xferRead,  // 1 = read
  output logic            rdStrobe   // ask next byte
);
  initial begin
    wrByte = '{1'b0, 8'hA5};
    xferStart = 1'b0;
    xferRead = 1'b0;
    rdStrobe = 1'b0;
  end
  task automatic start(input logic rd);
    @(negedge clk);
    xferStart = 1'b1;
    xferRead = rd;
    @(negedge clk);
    xferStart = 1'b0;
  endtask
  // idle data is the inverse of the lower data byte d[7:0]
  task automatic wr(input logic [1:0] sel, input logic [15:0] d, input int n);
    start(1'b0);
    wrByte = '{1'b1, {6'h00, sel}};
    @(negedge clk);
    if (n == 2) begin
      wrByte = '{1'b1, d[15:8]};
      @(negedge clk);
    end
    if (n > 0) begin
      wrByte = '{1'b1, d[7:0]};
      @(negedge clk);
    end
    wrByte = '{1'b0, ~d[7:0]};
  endtask
  task automatic rd(input int n, output logic [15:0] v);
    v = 16'h0000;
    start(1'b1);
    repeat (n) begin
      rdStrobe = 1'b1;
      @(negedge clk);
      rdStrobe = 1'b0;
      for (int i = 0; i < 4 && !rdValid; i++) @(negedge clk);
      v = rdValid ? {v[7:0], rdData} : 16'hXXXX;
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking bench of the temperature sensor register set
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tsr_pkg::*;
  localparam int unsigned CONV = 8;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] sensorCode = 12'h000;
  logic [31:0] seed = 32'h4DA9D229;
  logic [15:0] v;
  logic [15:0] d;
  logic [7:0]  c;
  logic [7:0]  rdData;
  logic        rdValid;
  logic        convDone;
  logic        alertOut;
  logic        xferStart;
  logic        xferRead;
  logic        rdStrobe;
  tsr_wbyte_t  wrByte;
  int          failures = 0;
  int          num_checks = 0;
  always #12.5 clk = ~clk;
  tsr_register_set #(.CONV9_CYCLES(CONV)) tsr_register_set_i (
    .clk(clk), .reset_n(reset_n), .clkEn(1'b1), .xferStart(xferStart),
    .xferRead(xferRead), .wrByte(wrByte), .rdStrobe(rdStrobe),
    .sensorCode(sensorCode), .rdData(rdData), .rdValid(rdValid),
    .convDone(convDone), .alertOut(alertOut));
  tsr_host_model tsr_host_model_i (
    .clk(clk), .rdData(rdData), .rdValid(rdValid), .wrByte(wrByte),
    .xferStart(xferStart), .xferRead(xferRead), .rdStrobe(rdStrobe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] expTemp(input logic [11:0] t, input logic [1:0] r);
    return {t, 4'h0} & ~(16'h007F >> r);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic waitConv();
    int i;
    for (i = 0; i < 200 && convDone !== 1'b1; i++) @(negedge clk);
    if (i == 200) begin
      failures++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    // no selector sent: temperature is current after reset
    tsr_host_model_i.rd(2, v);
    check(v, 16'h0000, "temp reset");
    check(16'(alertOut), 16'h0001, "alert idle");
    tsr_host_model_i.wr(2'h1, 16'h0000, 0);
    tsr_host_model_i.rd(1, v);
    check(v, 16'h0000, "cfg reset");
    tsr_host_model_i.wr(2'h2, 16'h0000, 0);
    tsr_host_model_i.rd(2, v);
    check(v, 16'h4B00, "lower reset");
    tsr_host_model_i.wr(2'h3, 16'h0000, 0);
    tsr_host_model_i.rd(2, v);
    check(v, 16'h5000, "upper reset");
    $display("test reset done");
    tsr_host_model_i.wr(2'h1, 16'h0001, 1);
    for (int s = 2; s < 4; s++) begin
      d = 16'(rnd());
      tsr_host_model_i.wr(s[1:0], d, 2);
      tsr_host_model_i.rd(2, v);
      check(v, d & 16'hFF80, "limit");
    end
    tsr_host_model_i.wr(2'h3, 16'h7F80, 2);
    $display("test limits done");
    for (int r = 0; r < 4; r++) begin
      sensorCode = 12'(rnd()) & 12'hF7F;
      c = {1'b1, r[1:0], 5'h01};
      tsr_host_model_i.wr(2'h1, {8'h00, c}, 1);
      waitConv();
      repeat (2) @(negedge clk);
      tsr_host_model_i.rd(1, v);
      check(v, {8'h00, c & 8'h7F}, "oneshot");
      tsr_host_model_i.wr(2'h0, 16'h1234, 2);
      tsr_host_model_i.rd(2, v);
      check(v, expTemp(sensorCode, r[1:0]), "temp");
    end
    $display("test oneshot done");
    sensorCode = 12'h7F0;
    tsr_host_model_i.wr(2'h3, 16'h0000, 2);
    tsr_host_model_i.wr(2'h2, 16'h8000, 2);
    tsr_host_model_i.wr(2'h1, 16'h0000, 1);
    waitConv();
    repeat (2) @(negedge clk);
    check(16'(alertOut), 16'h0000, "alert low");
    tsr_host_model_i.wr(2'h1, 16'h0004, 1);
    check(16'(alertOut), 16'h0001, "alert high");
    $display("test alert done");
    // comparator state is set; two conversions below the lower limit are needed to clear it
    tsr_host_model_i.wr(2'h1, 16'h0001, 1);
    tsr_host_model_i.wr(2'h2, 16'h0000, 2);
    sensorCode = 12'hF00;
    tsr_host_model_i.wr(2'h1, 16'h000C, 1);
    waitConv();
    repeat (2) @(negedge clk);
    check(16'(alertOut), 16'h0001, "fault queue first");
    waitConv();
    repeat (2) @(negedge clk);
    check(16'(alertOut), 16'h0000, "fault queue second");
    $display("test fault queue done");
    tsr_host_model_i.wr(2'h1, 16'h0001, 1);
    sensorCode = 12'h100;
    tsr_host_model_i.wr(2'h1, 16'h0006, 1);
    tsr_host_model_i.rd(1, v);
    check(v, 16'h0006, "int cfg");
    check(16'(alertOut), 16'h0000, "int cleared");
    waitConv();
    repeat (2) @(negedge clk);
    check(16'(alertOut), 16'h0001, "int set");
    tsr_host_model_i.rd(1, v);
    check(16'(alertOut), 16'h0000, "int read clear");
    $display("test interrupt done");
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    tsr_host_model_i.rd(2, v);
    check(v, 16'h0000, "temp after reset");
    check(16'(alertOut), 16'h0001, "alert after reset");
    tsr_host_model_i.wr(2'h1, 16'h0000, 0);
    tsr_host_model_i.rd(1, v);
    check(v, 16'h0000, "cfg after reset");
    $display("test midrun reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
